// [hdl/pwr_result_regs.svh]
// Function
// - Cycle length count is 24-bit unsigned, conversions per computation cycle, resets to 4000.
// - Computation cycles complete at master clock over divider over 1024 times count.
// - Full-scale pulse rate on all three outputs is clock times scale over 2048.
// - Pulse scale is a signed fraction; negative scale pulses like its magnitude.
// - At 4 kHz sample rate, energy pulse rate stays at or below 2 kHz.
// - Latest current, voltage samples at 7 and 8, their product at 9.
// - Instantaneous current, voltage, power are 24-bit signed fractions, minus one to below one.
// - Each cycle, mean of instantaneous power over its conversions is stored at 10.
// - Mean active power is a signed fraction, limited from minus one to below one.
// - Power offset is added to each accumulated power term; resets zero, at 14.
// - RMS current and voltage computed each cycle, stored at 11 and 12.
// - RMS results are unsigned fractions, point left of MSB, zero to below one.
// - Line ratio is host written or measured; resets to the 0.0125 code.
// - Line ratio is a signed fraction; negative values carry no meaning.
// - Internal clock is master clock over a 4-bit ratio 1 to 16; zero selects 16.
// - Data ready flag pulses for one clock when each computation cycle's results are published, after the divisions and square roots.
`ifndef PWR_RESULT_REGS_SVH
`define PWR_RESULT_REGS_SVH

// ****************************************
// Register addresses
// ****************************************
`define PWR_ADDR_CYCLE 5'h05
`define PWR_ADDR_PSCALE 5'h06
`define PWR_ADDR_ICUR 5'h07
`define PWR_ADDR_IVOLT 5'h08
`define PWR_ADDR_IPOW 5'h09
`define PWR_ADDR_PMEAN 5'h0A
`define PWR_ADDR_RMS_CUR 5'h0B
`define PWR_ADDR_RMS_VOLT 5'h0C
`define PWR_ADDR_RATIO 5'h0D
`define PWR_ADDR_POWER_OFFSET 5'h0E

// ****************************************
// Reset values
// ****************************************
`define PWR_CYCLE_RST 24'h000FA0
`define PWR_PSCALE_RST 24'h800000
`define PWR_RATIO_RST 24'h01999A
`define PWR_POWER_OFFSET_RST 24'h000000

// ****************************************
// Fixed-point limits and timing counts
// ****************************************
`define PWR_POS_MAX 24'h7FFFFF
`define PWR_NEG_MIN 24'h800000
`define PWR_UNS_MAX 24'hFFFFFF
`define PWR_K_ZERO_SEL 5'h10
`define PWR_CONV_LAST 10'h3FF
`define PWR_DIV_LAST 6'h31
`define PWR_SQRT_LAST 5'h18
`define PWR_PULSE_GAP 2'h2

`endif

// [hdl/pwr_pkg.sv]
package pwr_pkg;

    typedef enum logic [2:0] {
        PWR_ST_IDLE = 3'b000,
        PWR_ST_DIV_P = 3'b001,
        PWR_ST_DIV_I = 3'b010,
        PWR_ST_DIV_V = 3'b011,
        PWR_ST_SQRT = 3'b100,
        PWR_ST_PUBLISH = 3'b101
    } pwr_state_t;

    typedef logic [23:0] pwr_word_t;

endpackage : pwr_pkg

// [hdl/pwr_sqrt_seq.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pwr_result_regs.svh"
module pwr_sqrt_seq import pwr_pkg::*; (
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_start,
    input wire logic [49:0] i_radicand,
    output logic [24:0] o_root,
    output logic o_done
);

    // ****************************************
    // Bit-serial restoring square root
    // ****************************************
    logic [49:0] rad_reg;
    logic [26:0] rem_reg;
    logic [4:0] step_reg;
    logic busy_reg;

    wire [26:0] rem_shift = {rem_reg[24:0], rad_reg[49:48]};
    wire [27:0] trial = {1'b0, rem_shift} - {1'b0, o_root, 2'b01};
    wire fits = !trial[27];

    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            rad_reg <= 50'h0;
            rem_reg <= 27'h0;
            step_reg <= 5'h0;
            busy_reg <= 1'b0;
            o_root <= 25'h0;
            o_done <= 1'b0;
        end else if (i_start) begin
            rad_reg <= i_radicand;
            rem_reg <= 27'h0;
            step_reg <= 5'h0;
            busy_reg <= 1'b1;
            o_root <= 25'h0;
            o_done <= 1'b0;
        end else if (busy_reg) begin
            rad_reg <= {rad_reg[47:0], 2'b00};
            rem_reg <= fits ? trial[26:0] : rem_shift;
            o_root <= {o_root[23:0], fits};
            step_reg <= step_reg + 5'h01;
            busy_reg <= (step_reg != `PWR_SQRT_LAST);
            o_done <= (step_reg == `PWR_SQRT_LAST);
        end else begin
            o_done <= 1'b0;
        end
    end

endmodule : pwr_sqrt_seq
`default_nettype wire

// [hdl/pwr_result_bank.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pwr_result_regs.svh"
module pwr_result_bank import pwr_pkg::*; (
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_conv_run,
    input wire logic [3:0] i_clk_div_ratio,
    input wire logic [23:0] i_adc_current,
    input wire logic [23:0] i_adc_voltage,
    input wire logic i_ratio_meas_valid,
    input wire logic [23:0] i_ratio_meas,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [4:0] i_reg_addr,
    input wire logic [23:0] i_reg_wdata,
    output logic [23:0] o_reg_rdata,
    output logic o_reg_rvalid,
    output logic o_data_ready_flag,
    output logic o_energy_pulse_out_a,
    output logic o_energy_pulse_out_b,
    output logic o_energy_pulse_out_c
);

    function automatic logic wr_sel(input logic wr, input logic [4:0] addr, input logic [4:0] target);
        wr_sel = wr && (addr == target);
    endfunction : wr_sel

    // ****************************************
    // Registers
    // ****************************************
    pwr_word_t cycle_length_count_reg;
    pwr_word_t pulse_frequency_scale_reg;
    pwr_word_t instant_current_reg;
    pwr_word_t instant_voltage_reg;
    pwr_word_t instant_power_reg;
    pwr_word_t mean_active_power_reg;
    pwr_word_t rms_reg [2];
    pwr_word_t line_to_sample_ratio_reg;
    pwr_word_t power_offset_reg;

    // ****************************************
    // Clock divider and conversion timing
    // ****************************************
    logic [3:0] kdiv_cnt_reg;
    logic dclk_en_reg;
    logic [9:0] conv_cnt_reg;
    logic conv_stb_reg;
    logic [23:0] cyc_cnt_reg;

    wire [4:0] k_eff = (i_clk_div_ratio == 4'h0) ? `PWR_K_ZERO_SEL : {1'b0, i_clk_div_ratio};
    wire kdiv_last = ({1'b0, kdiv_cnt_reg} >= (k_eff - 5'h01));
    wire [23:0] n_eff = (cycle_length_count_reg == 24'h0) ? 24'h000001 : cycle_length_count_reg;
    wire cycle_end = conv_stb_reg && (cyc_cnt_reg >= (n_eff - 24'h000001));

    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            kdiv_cnt_reg <= 4'h0;
            dclk_en_reg <= 1'b0;
        end else if (!i_conv_run) begin
            kdiv_cnt_reg <= 4'h0;
            dclk_en_reg <= 1'b0;
        end else begin
            dclk_en_reg <= kdiv_last;
            kdiv_cnt_reg <= kdiv_last ? 4'h0 : kdiv_cnt_reg + 4'h1;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            conv_cnt_reg <= 10'h0;
            conv_stb_reg <= 1'b0;
            cyc_cnt_reg <= 24'h0;
        end else if (!i_conv_run) begin
            conv_cnt_reg <= 10'h0;
            conv_stb_reg <= 1'b0;
            cyc_cnt_reg <= 24'h0;
        end else begin
            conv_stb_reg <= dclk_en_reg && (conv_cnt_reg == `PWR_CONV_LAST);
            if (dclk_en_reg) begin
                conv_cnt_reg <= conv_cnt_reg + 10'h001;
            end
            if (conv_stb_reg) begin
                cyc_cnt_reg <= cycle_end ? 24'h0 : cyc_cnt_reg + 24'h000001;
            end
        end
    end

    // ****************************************
    // Sample capture and accumulation
    // ****************************************
    wire signed [47:0] iv_prod = $signed(i_adc_current) * $signed(i_adc_voltage);
    wire [23:0] p_new = (iv_prod[47:46] == 2'b01) ? `PWR_POS_MAX : iv_prod[46:23];
    wire [24:0] p_term = {p_new[23], p_new} + {power_offset_reg[23], power_offset_reg};
    wire [23:0] adc_in [2];
    assign adc_in[0] = i_adc_current;
    assign adc_in[1] = i_adc_voltage;

    logic [49:0] sum_p_reg;
    logic [49:0] snap_p_reg;
    logic [49:0] sum_sq_reg [2];
    logic [49:0] snap_sq_reg [2];
    logic [25:0] ms_reg [2];
    logic [24:0] root [2];
    logic [1:0] sqrt_done;
    logic sqrt_start_reg;
    logic calc_start_reg;

    wire [49:0] p_sum = sum_p_reg + {{25{p_term[24]}}, p_term};

    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            instant_current_reg <= 24'h0;
            instant_voltage_reg <= 24'h0;
            instant_power_reg <= 24'h0;
            sum_p_reg <= 50'h0;
            snap_p_reg <= 50'h0;
            calc_start_reg <= 1'b0;
        end else begin
            calc_start_reg <= cycle_end;
            if (!i_conv_run) begin
                sum_p_reg <= 50'h0;
            end else if (conv_stb_reg) begin
                instant_current_reg <= i_adc_current;
                instant_voltage_reg <= i_adc_voltage;
                instant_power_reg <= p_new;
                sum_p_reg <= cycle_end ? 50'h0 : p_sum;
                if (cycle_end) begin
                    snap_p_reg <= p_sum;
                end
            end
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
            wire signed [47:0] sq = $signed(adc_in[ch]) * $signed(adc_in[ch]);
            wire [49:0] sq_sum = sum_sq_reg[ch] + {24'h0, sq[47:22]};

            always_ff @(posedge i_core_clk or posedge i_reset) begin
                if (i_reset) begin
                    sum_sq_reg[ch] <= 50'h0;
                    snap_sq_reg[ch] <= 50'h0;
                end else if (!i_conv_run) begin
                    sum_sq_reg[ch] <= 50'h0;
                end else if (conv_stb_reg) begin
                    sum_sq_reg[ch] <= cycle_end ? 50'h0 : sq_sum;
                    if (cycle_end) begin
                        snap_sq_reg[ch] <= sq_sum;
                    end
                end
            end

            pwr_sqrt_seq u_sqrt (
                .i_core_clk(i_core_clk),
                .i_reset(i_reset),
                .i_start(sqrt_start_reg),
                .i_radicand({ms_reg[ch], 24'h0}),
                .o_root(root[ch]),
                .o_done(sqrt_done[ch])
            );
        end
    endgenerate

    // ****************************************
    // Cycle-end computation sequence
    // ****************************************
    pwr_state_t state_reg;
    logic [49:0] div_num_reg;
    logic [24:0] div_rem_reg;
    logic [5:0] div_step_reg;
    logic [49:0] q_p_reg;
    logic p_neg_reg;

    wire [25:0] div_trial = {div_rem_reg, div_num_reg[49]} - {2'b00, n_eff};
    wire div_fits = !div_trial[25];
    wire [49:0] div_q = {div_num_reg[48:0], div_fits};
    wire div_last = (div_step_reg == `PWR_DIV_LAST);
    wire [49:0] p_mag = snap_p_reg[49] ? (50'h0 - snap_p_reg) : snap_p_reg;
    wire [23:0] p_pos = (|q_p_reg[49:23]) ? `PWR_POS_MAX : q_p_reg[23:0];
    wire [23:0] p_neg = (q_p_reg > {26'h0, `PWR_NEG_MIN}) ? `PWR_NEG_MIN : (24'h0 - q_p_reg[23:0]);
    wire [23:0] p_mean = p_neg_reg ? p_neg : p_pos;

    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            state_reg <= PWR_ST_IDLE;
            div_num_reg <= 50'h0;
            div_rem_reg <= 25'h0;
            div_step_reg <= 6'h0;
            q_p_reg <= 50'h0;
            p_neg_reg <= 1'b0;
            ms_reg[0] <= 26'h0;
            ms_reg[1] <= 26'h0;
            sqrt_start_reg <= 1'b0;
        end else begin
            sqrt_start_reg <= 1'b0;
            case (state_reg)
                PWR_ST_IDLE: begin
                    if (calc_start_reg) begin
                        state_reg <= PWR_ST_DIV_P;
                        div_num_reg <= p_mag;
                        p_neg_reg <= snap_p_reg[49];
                        div_rem_reg <= 25'h0;
                        div_step_reg <= 6'h0;
                    end
                end
                PWR_ST_DIV_P, PWR_ST_DIV_I, PWR_ST_DIV_V: begin
                    div_num_reg <= div_q;
                    div_rem_reg <= div_fits ? div_trial[24:0] : {div_rem_reg[23:0], div_num_reg[49]};
                    div_step_reg <= div_step_reg + 6'h01;
                    if (div_last) begin
                        div_rem_reg <= 25'h0;
                        div_step_reg <= 6'h0;
                        if (state_reg == PWR_ST_DIV_P) begin
                            q_p_reg <= div_q;
                            div_num_reg <= snap_sq_reg[0];
                            state_reg <= PWR_ST_DIV_I;
                        end else if (state_reg == PWR_ST_DIV_I) begin
                            ms_reg[0] <= div_q[25:0];
                            div_num_reg <= snap_sq_reg[1];
                            state_reg <= PWR_ST_DIV_V;
                        end else begin
                            ms_reg[1] <= div_q[25:0];
                            sqrt_start_reg <= 1'b1;
                            state_reg <= PWR_ST_SQRT;
                        end
                    end
                end
                PWR_ST_SQRT: begin
                    if (&sqrt_done) begin
                        state_reg <= PWR_ST_PUBLISH;
                    end
                end
                PWR_ST_PUBLISH: begin
                    state_reg <= PWR_ST_IDLE;
                end
                default: begin
                    state_reg <= PWR_ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Result publication
    // ****************************************
    wire publish = (state_reg == PWR_ST_PUBLISH);

    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            mean_active_power_reg <= 24'h0;
            rms_reg[0] <= 24'h0;
            rms_reg[1] <= 24'h0;
            o_data_ready_flag <= 1'b0;
        end else begin
            o_data_ready_flag <= publish;
            if (publish) begin
                mean_active_power_reg <= p_mean;
                rms_reg[0] <= root[0][24] ? `PWR_UNS_MAX : root[0][23:0];
                rms_reg[1] <= root[1][24] ? `PWR_UNS_MAX : root[1][23:0];
            end
        end
    end

    // ****************************************
    // Energy pulse generator
    // ****************************************
    wire [23:0] pwr_mag = mean_active_power_reg[23] ? (24'h0 - mean_active_power_reg) : mean_active_power_reg;
    wire [23:0] scl_mag = pulse_frequency_scale_reg[23] ? (24'h0 - pulse_frequency_scale_reg)
                                                        : pulse_frequency_scale_reg;
    logic [33:0] e_acc_reg;
    logic e_pend_reg;
    logic [1:0] e_gap_reg;

    wire [47:0] e_prod = pwr_mag * scl_mag;
    wire [34:0] e_sum = {1'b0, e_acc_reg} + {11'h0, e_prod[46:23]};
    wire e_fire = e_pend_reg && (e_gap_reg == `PWR_PULSE_GAP);

    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            e_acc_reg <= 34'h0;
            e_pend_reg <= 1'b0;
            e_gap_reg <= `PWR_PULSE_GAP;
            o_energy_pulse_out_a <= 1'b0;
            o_energy_pulse_out_b <= 1'b0;
            o_energy_pulse_out_c <= 1'b0;
        end else begin
            o_energy_pulse_out_a <= e_fire;
            o_energy_pulse_out_b <= e_fire;
            o_energy_pulse_out_c <= e_fire;
            if (i_conv_run) begin
                e_acc_reg <= e_sum[33:0];
            end
            e_pend_reg <= (i_conv_run && e_sum[34]) || (e_pend_reg && !e_fire);
            if (e_fire) begin
                e_gap_reg <= 2'h0;
            end else if (conv_stb_reg && (e_gap_reg != `PWR_PULSE_GAP)) begin
                e_gap_reg <= e_gap_reg + 2'h1;
            end
        end
    end

    // ****************************************
    // Register access
    // ****************************************
    wire ratio_meas_ok = i_conv_run && i_ratio_meas_valid && !i_ratio_meas[23];
    wire [23:0] rd_mux =
        (i_reg_addr == `PWR_ADDR_CYCLE) ? cycle_length_count_reg :
        (i_reg_addr == `PWR_ADDR_PSCALE) ? pulse_frequency_scale_reg :
        (i_reg_addr == `PWR_ADDR_ICUR) ? instant_current_reg :
        (i_reg_addr == `PWR_ADDR_IVOLT) ? instant_voltage_reg :
        (i_reg_addr == `PWR_ADDR_IPOW) ? instant_power_reg :
        (i_reg_addr == `PWR_ADDR_PMEAN) ? mean_active_power_reg :
        (i_reg_addr == `PWR_ADDR_RMS_CUR) ? rms_reg[0] :
        (i_reg_addr == `PWR_ADDR_RMS_VOLT) ? rms_reg[1] :
        (i_reg_addr == `PWR_ADDR_RATIO) ? line_to_sample_ratio_reg :
        (i_reg_addr == `PWR_ADDR_POWER_OFFSET) ? power_offset_reg : 24'h0;

    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            cycle_length_count_reg <= `PWR_CYCLE_RST;
            pulse_frequency_scale_reg <= `PWR_PSCALE_RST;
            line_to_sample_ratio_reg <= `PWR_RATIO_RST;
            power_offset_reg <= `PWR_POWER_OFFSET_RST;
            o_reg_rdata <= 24'h0;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd) begin
                o_reg_rdata <= rd_mux;
            end
            if (wr_sel(i_reg_wr, i_reg_addr, `PWR_ADDR_CYCLE)) begin
                cycle_length_count_reg <= i_reg_wdata;
            end
            if (wr_sel(i_reg_wr, i_reg_addr, `PWR_ADDR_PSCALE)) begin
                pulse_frequency_scale_reg <= i_reg_wdata;
            end
            if (wr_sel(i_reg_wr, i_reg_addr, `PWR_ADDR_RATIO)) begin
                line_to_sample_ratio_reg <= i_reg_wdata;
            end else if (ratio_meas_ok) begin
                line_to_sample_ratio_reg <= i_ratio_meas;
            end
            if (wr_sel(i_reg_wr, i_reg_addr, `PWR_ADDR_POWER_OFFSET)) begin
                power_offset_reg <= i_reg_wdata;
            end
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    logic [14:0] conv_gap_reg;
    logic conv_seen_reg;

    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            conv_gap_reg <= 15'h0;
            conv_seen_reg <= 1'b0;
        end else begin
            conv_gap_reg <= conv_stb_reg ? 15'h0 : conv_gap_reg + 15'h0001;
            conv_seen_reg <= i_conv_run && (conv_seen_reg || conv_stb_reg);
        end
    end

    conv_spacing_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
        conv_stb_reg && conv_seen_reg |-> conv_gap_reg == ({k_eff, 10'h000} - 15'h0001))
        else $error("conversion spacing is not 1024 divided clocks");

    dclk_div_two_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
        (dclk_en_reg && k_eff == 5'h02 && i_conv_run) ##1 i_conv_run |-> !dclk_en_reg ##1 dclk_en_reg)
        else $error("divided clock enable wrong for ratio two");

    cycle_write_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
        i_reg_wr && i_reg_addr == `PWR_ADDR_CYCLE |=> cycle_length_count_reg == $past(i_reg_wdata))
        else $error("cycle length count not written");

    inst_power_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
        conv_stb_reg && i_conv_run |=> instant_power_reg == $past(p_new) && instant_current_reg == $past(i_adc_current))
        else $error("instantaneous registers not updated on conversion");

    data_ready_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
        calc_start_reg && state_reg == PWR_ST_IDLE |-> ##[150:260] o_data_ready_flag)
        else $error("data ready not raised after cycle end");

    result_hold_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
        !publish |=> $stable(mean_active_power_reg) && $stable(rms_reg[0]) && $stable(rms_reg[1]))
        else $error("results changed outside publication");

    pulse_rate_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
        o_energy_pulse_out_a |=> !o_energy_pulse_out_a [*8])
        else $error("energy pulses too close together");

    ratio_negative_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
        i_ratio_meas_valid && i_ratio_meas[23] && !i_reg_wr |=> $stable(line_to_sample_ratio_reg))
        else $error("negative measured ratio was accepted");

    offset_write_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
        i_reg_wr && i_reg_addr == `PWR_ADDR_POWER_OFFSET |=> power_offset_reg == $past(i_reg_wdata))
        else $error("power offset not written");

endmodule : pwr_result_bank
`default_nettype wire

// [testbench/pwr_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ****
// Host register access
// ****
module pwr_host_model (
    input wire logic i_core_clk,
    input wire logic [23:0] i_reg_rdata,
    input wire logic i_reg_rvalid,
    output logic o_reg_wr,
    output logic o_reg_rd,
    output logic [4:0] o_reg_addr,
    output logic [23:0] o_reg_wdata
);
    initial begin
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
        o_reg_addr = 5'h00;
        o_reg_wdata = 24'h000000;
    end
    task automatic wr(input logic [4:0] a, input logic [23:0] d);
        @(posedge i_core_clk);
        #1 o_reg_wr = 1'b1;
        o_reg_addr = a;
        o_reg_wdata = d;
        @(posedge i_core_clk);
        #1 o_reg_wr = 1'b0;
        o_reg_wdata = ~d;
    endtask : wr
    task automatic rd(input logic [4:0] a, output logic [23:0] d);
        @(posedge i_core_clk);
        #1 o_reg_rd = 1'b1;
        o_reg_addr = a;
        @(posedge i_core_clk);
        #1 d = i_reg_rvalid ? i_reg_rdata : ~i_reg_rdata;
        o_reg_rd = 1'b0;
    endtask : rd
endmodule : pwr_host_model
`default_nettype wire

// [testbench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top import pwr_pkg::*; ;
    localparam logic [4:0] RA [6] = '{5'h05, 5'h06, 5'h0D, 5'h0E, 5'h1F, 5'h07};
    localparam pwr_word_t RV [6] = '{24'h000FA0, 24'h800000, 24'h01999A, 24'h000000, 24'h000000, 24'h000000};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic run = 1'b0;
    logic mv = 1'b0;
    logic [3:0] kdiv = 4'h1;
    pwr_word_t adc_i = 24'h0, adc_v = 24'h0, mval = 24'h0;
    logic wr, rd, rvalid, data_ready_flag, pa, pb, pc;
    logic [4:0] addr;
    pwr_word_t wdata, rdata;
    int cmp_count = 0;
    int mismatches = 0;
    int pulses = 0;
    always #2.5 clk = ~clk;
    pwr_result_bank dut_u (.i_core_clk(clk), .i_reset(rst), .i_conv_run(run), .i_clk_div_ratio(kdiv),
        .i_adc_current(adc_i), .i_adc_voltage(adc_v), .i_ratio_meas_valid(mv), .i_ratio_meas(mval),
        .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
        .o_reg_rvalid(rvalid), .o_data_ready_flag(data_ready_flag), .o_energy_pulse_out_a(pa),
        .o_energy_pulse_out_b(pb), .o_energy_pulse_out_c(pc));
    pwr_host_model host_u (.i_core_clk(clk), .i_reg_rdata(rdata), .i_reg_rvalid(rvalid), .o_reg_wr(wr),
        .o_reg_rd(rd), .o_reg_addr(addr), .o_reg_wdata(wdata));
    // ****
    // Checking and expectations
    // ****
    task automatic check(input pwr_word_t seen, input pwr_word_t exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic print_verdict();
        $display("compares=%0d mismatches=%0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict
    task automatic rc(input logic [4:0] a, input pwr_word_t e);
        pwr_word_t d;
        host_u.rd(a, d);
        check(d, e);
    endtask : rc
    task automatic wait_flag(output int n);
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (data_ready_flag !== 1'b1 && n < 40000);
        if (n >= 40000) check(24'h0, 24'h1);
    endtask : wait_flag
    function automatic pwr_word_t f_prod(input pwr_word_t a, input pwr_word_t b);
        logic signed [47:0] p;
        p = ($signed(a) * $signed(b)) >>> 23;
        return (p > 48'sh7FFFFF) ? 24'h7FFFFF : p[23:0];
    endfunction : f_prod
    function automatic pwr_word_t f_rms(input pwr_word_t x);
        return (x == 24'h800000) ? 24'hFFFFFF : (x[23] ? (~x + 24'h1) : x) << 1;
    endfunction : f_rms
    always @(negedge clk) begin
        if (pa | pb | pc) begin
            pulses++;
            check({21'h0, pa, pb, pc}, 24'h7);
        end
    end
    // Cut a hang short
    initial begin
        #400000;
        mismatches++;
        print_verdict();
    end
    initial begin
        int n;
        pwr_word_t v, off, d;
        n = $urandom(32'h0909e7f5);
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        for (int j = 0; j < 6; j++) rc(RA[j], RV[j]);
        $display("reset test done");
        for (int j = 0; j < 6; j++) begin
            v = $urandom;
            host_u.wr(RA[j], v);
            rc(RA[j], j > 3 ? 24'h0 : v);
        end
        $display("access test done");
        run = 1'b1;
        for (int j = 0; j < 2; j++) begin
            v = $urandom;
            v[23] = j[0];
            @(posedge clk);
            #1 mv = 1'b1;
            mval = v;
            @(posedge clk);
            #1 mv = 1'b0;
            if (j == 0) d = v;
            rc(5'h0D, d);
        end
        $display("ratio test done");
        for (int k = 1; k <= 3; k++) begin
            @(posedge clk);
            #1 run = 1'b0;
            kdiv = (k == 3) ? 4'h0 : 4'(k);
            adc_i = (k == 1) ? 24'h800000 : 24'h400000;
            adc_v = (k == 1) ? 24'h800000 : $urandom & 24'h3FF800;
            off = (k == 1) ? 24'h0 : $urandom & 24'h0FFFFF;
            host_u.wr(5'h05, 24'h000001);
            host_u.wr(5'h0E, off);
            host_u.wr(5'h06, 24'h800000);
            @(posedge clk);
            #1 run = 1'b1;
            wait_flag(n);
            pulses = 0;
            wait_flag(n);
            check(24'(n), 24'((k == 3) ? 16384 : 1024 * k));
            d = f_prod(adc_i, adc_v);
            rc(5'h07, adc_i);
            rc(5'h08, adc_v);
            rc(5'h09, d);
            rc(5'h0A, d + off);
            rc(5'h0B, f_rms(adc_i));
            rc(5'h0C, f_rms(adc_v));
            if (k == 1) begin
                repeat (8192) @(posedge clk);
                check(24'(pulses >= 3 && pulses <= 4), 24'h1);
            end
            $display("conversion test %0d done", k);
        end
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
